// ==== rtl/node_request_filter.sv ====
// node request filter registers and request routing decision
//
// Overview of operation
// (RULE1) a set bit n of the low async filter accepts async requests from local node n.
// (RULE2) the low async filter is written through a set address and a clear address.
// (RULE3) the low async filter behaves like the high one but covers nodes 0 to 31.
// (RULE4) high physical filter bits 30 to 18 send physical requests of nodes 62 to 50 onward.
// (RULE5) a physical request is checked against the async filters first, then the physical one.
// (RULE6) a physical request lacking its physical bit goes to the async receive request context.
// (RULE7) high physical filter bit 31 accepts all requests from remote buses; the code applies it to physical requests only, after async bit 31.
// (RULE8) the high physical filter has one set address and one clear address.
// (RULE9) high async filter bit 31 accepts remote buses; bits 30 to 0 enable nodes 62 to 32.
// (RULE10) high physical filter bits 17 to 0 send physical requests of nodes 49 to 32 onward.
// (RULE11) ones written set or clear bits, zeros do nothing, set address reads back, reset is zero.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module node_request_filter
  import node_filter_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic req_valid,
  input wire logic req_phys,
  input wire logic [9:0] req_bus_id,
  input wire logic [5:0] req_node_id,
  output logic dec_valid,
  output logic dec_accept,
  output logic dec_to_phys,
  output logic dec_to_async
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] async_high;
    logic [31:0] async_low;
    logic [31:0] phys_high;
    logic [31:0] phys_low;
    logic [31:0] rdata;
    logic dec_valid;
    logic dec_accept;
    logic dec_to_phys;
    logic dec_to_async;
  } state_t;

  state_t st;
  state_t next_st;
  logic remote;
  logic [4:0] idx;
  logic async_ok;
  logic phys_ok;
  logic async_accept_remote_buses;
  logic phys_accept_remote_buses;
  route_t route;

  // ****************************************
  // routing decision
  // ****************************************
  always_comb begin
    async_accept_remote_buses = st.async_high[ALL_BUSES_BIT];
    phys_accept_remote_buses = st.phys_high[ALL_BUSES_BIT];
    remote = (req_bus_id != {4'h0, LOCAL_BUS_ID}) && (req_bus_id != 10'h3FF);
    idx = req_node_id[4:0];
    if (remote) begin
      async_ok = async_accept_remote_buses; // RULE9
      phys_ok = phys_accept_remote_buses; // RULE7
    end else if (req_node_id < HIGH_NODE_BASE) begin
      async_ok = st.async_low[idx]; // RULE1 RULE3
      phys_ok = st.phys_low[idx];
    end else if (req_node_id == LOCAL_BUS_ID) begin
      // broadcast id has no filter bit
      async_ok = 1'b0;
      phys_ok = 1'b0;
    end else begin
      async_ok = st.async_high[idx]; // RULE9
      phys_ok = st.phys_high[idx]; // RULE4 RULE10
    end
    // async check always first, physical only refines the target
    if (!async_ok) begin
      route = ROUTE_NONE; // RULE5
    end else if (req_phys && phys_ok) begin
      route = ROUTE_PHYS; // RULE5
    end else begin
      route = ROUTE_ASYNC; // RULE6
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h00000000;
    if (wr) begin
      unique case (addr)
        ASYNC_HIGH_SET_ADDR: next_st.async_high = st.async_high | wdata; // RULE11
        ASYNC_HIGH_CLEAR_ADDR: next_st.async_high = st.async_high & ~wdata;
        ASYNC_LOW_SET_ADDR: next_st.async_low = st.async_low | wdata; // RULE2
        ASYNC_LOW_CLEAR_ADDR: next_st.async_low = st.async_low & ~wdata; // RULE2
        PHYS_HIGH_SET_ADDR: next_st.phys_high = st.phys_high | wdata; // RULE8
        PHYS_HIGH_CLEAR_ADDR: next_st.phys_high = st.phys_high & ~wdata; // RULE8
        PHYS_LOW_SET_ADDR: next_st.phys_low = st.phys_low | wdata;
        PHYS_LOW_CLEAR_ADDR: next_st.phys_low = st.phys_low & ~wdata;
        default: ;
      endcase
    end
    if (rd) begin
      // both addresses read back, unmapped reads zero
      unique case (addr)
        ASYNC_HIGH_SET_ADDR, ASYNC_HIGH_CLEAR_ADDR: next_st.rdata = st.async_high;
        ASYNC_LOW_SET_ADDR, ASYNC_LOW_CLEAR_ADDR: next_st.rdata = st.async_low; // RULE11
        PHYS_HIGH_SET_ADDR, PHYS_HIGH_CLEAR_ADDR: next_st.rdata = st.phys_high; // RULE11
        PHYS_LOW_SET_ADDR, PHYS_LOW_CLEAR_ADDR: next_st.rdata = st.phys_low;
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    next_st.dec_valid = req_valid;
    next_st.dec_accept = req_valid && (route != ROUTE_NONE);
    next_st.dec_to_phys = req_valid && (route == ROUTE_PHYS);
    next_st.dec_to_async = req_valid && (route == ROUTE_ASYNC);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0; // RULE11
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign dec_valid = st.dec_valid;
  assign dec_accept = st.dec_accept;
  assign dec_to_phys = st.dec_to_phys;
  assign dec_to_async = st.dec_to_async;

  // ****************************************
  // checks
  // ****************************************
  property p_low_set;
    @(posedge clock) disable iff (srst)
      (wr && addr == ASYNC_LOW_SET_ADDR) |=> ((st.async_low & $past(wdata)) == $past(wdata));
  endproperty
  a_low_set: assert property (p_low_set) else $error("low async set lost"); // RULE2

  property p_phys_clear;
    @(posedge clock) disable iff (srst)
      (wr && addr == PHYS_HIGH_CLEAR_ADDR) |=> ((st.phys_high & $past(wdata)) == 32'h00000000);
  endproperty
  a_phys_clear: assert property (p_phys_clear) else $error("phys clear lost"); // RULE8

  property p_zero_keeps;
    @(posedge clock) disable iff (srst)
      (wr && addr == ASYNC_LOW_SET_ADDR && wdata == 32'h00000000) |=> $stable(st.async_low);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed bits"); // RULE11

  property p_readback;
    @(posedge clock) disable iff (srst)
      (rd && addr == PHYS_HIGH_SET_ADDR && !wr) |=> (rdata == $past(st.phys_high));
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong"); // RULE11

  property p_low_accept;
    @(posedge clock) disable iff (srst)
      (req_valid && !remote && req_node_id < HIGH_NODE_BASE) |=>
        (dec_accept == $past(st.async_low[idx]));
  endproperty
  a_low_accept: assert property (p_low_accept) else $error("low accept wrong"); // RULE1

  property p_phys_route;
    @(posedge clock) disable iff (srst)
      (req_valid && req_phys && async_ok && !phys_ok) |=> (dec_to_async && !dec_to_phys);
  endproperty
  a_phys_route: assert property (p_phys_route) else $error("fallback missing"); // RULE6

  property p_remote;
    @(posedge clock) disable iff (srst)
      (req_valid && remote && req_phys && st.async_high[31] && st.phys_high[31]) |=> dec_to_phys;
  endproperty
  a_remote: assert property (p_remote) else $error("remote accept wrong"); // RULE7

  property p_async_first;
    @(posedge clock) disable iff (srst)
      (req_valid && !async_ok) |=> (!dec_accept && !dec_to_phys);
  endproperty
  a_async_first: assert property (p_async_first) else $error("async check skipped"); // RULE5

  property p_high_phys;
    @(posedge clock) disable iff (srst)
      (req_valid && req_phys && !remote && req_node_id == 6'h32 && st.async_high[18]
        && st.phys_high[18]) |=> dec_to_phys;
  endproperty
  a_high_phys: assert property (p_high_phys) else $error("node 50 phys wrong"); // RULE4

  property p_low_clear;
    @(posedge clock) disable iff (srst)
      (wr && addr == ASYNC_LOW_CLEAR_ADDR) |=>
        ((st.async_low & $past(wdata)) == 32'h00000000);
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low async clear lost"); // RULE2

  property p_phys_set;
    @(posedge clock) disable iff (srst)
      (wr && addr == PHYS_HIGH_SET_ADDR) |=>
        ((st.phys_high & $past(wdata)) == $past(wdata));
  endproperty
  a_phys_set: assert property (p_phys_set) else $error("phys set lost"); // RULE8

  property p_high_set;
    @(posedge clock) disable iff (srst)
      (wr && addr == ASYNC_HIGH_SET_ADDR) |=>
        ((st.async_high & $past(wdata)) == $past(wdata));
  endproperty
  a_high_set: assert property (p_high_set) else $error("high async set lost"); // RULE9

  property p_high_clear;
    @(posedge clock) disable iff (srst)
      (wr && addr == ASYNC_HIGH_CLEAR_ADDR) |=>
        ((st.async_high & $past(wdata)) == 32'h00000000);
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("high async clear lost"); // RULE9

  property p_low_readback;
    @(posedge clock) disable iff (srst)
      (rd && addr == ASYNC_LOW_SET_ADDR && !wr) |=> (rdata == $past(st.async_low));
  endproperty
  a_low_readback: assert property (p_low_readback) else $error("low readback"); // RULE11

  property p_unmapped_read;
    @(posedge clock) disable iff (srst)
      (rd && addr[11:8] != 4'h1) |=> (rdata == 32'h00000000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read"); // RULE11

  property p_rdata_idle;
    @(posedge clock) disable iff (srst)
      !rd |=> (rdata == 32'h00000000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers"); // RULE11

  property p_isolated;
    @(posedge clock) disable iff (srst)
      (wr && addr == ASYNC_LOW_SET_ADDR) |=>
        ($stable(st.async_high) && $stable(st.phys_high));
  endproperty
  a_isolated: assert property (p_isolated) else $error("other filter hit"); // RULE2

  property p_reset_zero;
    @(posedge clock)
      srst |=> (st.async_low == FILTER_RESET && st.async_high == FILTER_RESET
        && st.phys_low == FILTER_RESET && st.phys_high == FILTER_RESET
        && rdata == 32'h00000000 && !dec_valid);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset not zero"); // RULE11

  property p_quiet;
    @(posedge clock) disable iff (srst)
      !req_valid |=> !(dec_valid || dec_accept || dec_to_phys || dec_to_async);
  endproperty
  a_quiet: assert property (p_quiet) else $error("decision without request"); // RULE1

  property p_dec_follows;
    @(posedge clock) disable iff (srst)
      req_valid |=> dec_valid;
  endproperty
  a_dec_follows: assert property (p_dec_follows) else $error("request dropped"); // RULE5

  property p_nonphys;
    @(posedge clock) disable iff (srst)
      (req_valid && !req_phys) |=> !dec_to_phys;
  endproperty
  a_nonphys: assert property (p_nonphys) else $error("async request to phys"); // RULE5

  property p_accept_split;
    @(posedge clock) disable iff (srst)
      (dec_accept == (dec_to_phys || dec_to_async)) && !(dec_to_phys && dec_to_async);
  endproperty
  a_accept_split: assert property (p_accept_split) else $error("route conflict"); // RULE6

  property p_remote_reject;
    @(posedge clock) disable iff (srst)
      (req_valid && remote && !async_accept_remote_buses) |=> (dec_valid && !dec_accept);
  endproperty
  a_remote_reject: assert property (p_remote_reject) else $error("remote reject"); // RULE9

  property p_remote_async;
    @(posedge clock) disable iff (srst)
      (req_valid && remote && async_accept_remote_buses && !phys_accept_remote_buses) |=>
        (dec_to_async && !dec_to_phys);
  endproperty
  a_remote_async: assert property (p_remote_async) else $error("remote fallback"); // RULE7

  property p_high_accept;
    @(posedge clock) disable iff (srst)
      (req_valid && !remote && req_node_id >= HIGH_NODE_BASE && req_node_id != LOCAL_BUS_ID)
        |=> (dec_accept == $past(st.async_high[req_node_id[4:0]]));
  endproperty
  a_high_accept: assert property (p_high_accept) else $error("high accept wrong"); // RULE9

  property p_node62_phys;
    @(posedge clock) disable iff (srst)
      (req_valid && req_phys && !remote && req_node_id == 6'h3E && st.async_high[30]
        && st.phys_high[30]) |=> dec_to_phys;
  endproperty
  a_node62_phys: assert property (p_node62_phys) else $error("node 62 phys"); // RULE4

  property p_node32_phys;
    @(posedge clock) disable iff (srst)
      (req_valid && req_phys && !remote && req_node_id == 6'h20 && st.async_high[0]
        && st.phys_high[0]) |=> dec_to_phys;
  endproperty
  a_node32_phys: assert property (p_node32_phys) else $error("node 32 phys"); // RULE10

  property p_broadcast;
    @(posedge clock) disable iff (srst)
      (req_valid && !remote && req_node_id == LOCAL_BUS_ID) |=> (dec_valid && !dec_accept);
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("broadcast accepted"); // RULE9

  property p_low_fallback;
    @(posedge clock) disable iff (srst)
      (req_valid && req_phys && !remote && req_node_id < HIGH_NODE_BASE
        && st.async_low[idx] && !st.phys_low[idx]) |=> (dec_to_async && !dec_to_phys);
  endproperty
  a_low_fallback: assert property (p_low_fallback) else $error("low fallback"); // RULE6
endmodule
`default_nettype wire

// ==== rtl/node_filter_pkg.sv ====
// constants for the node request filter bank
package node_filter_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ASYNC_HIGH_SET_ADDR = 12'h100;
  localparam logic [11:0] ASYNC_HIGH_CLEAR_ADDR = 12'h104;
  localparam logic [11:0] ASYNC_LOW_SET_ADDR = 12'h108;
  localparam logic [11:0] ASYNC_LOW_CLEAR_ADDR = 12'h10C;
  localparam logic [11:0] PHYS_HIGH_SET_ADDR = 12'h110;
  localparam logic [11:0] PHYS_HIGH_CLEAR_ADDR = 12'h114;
  localparam logic [11:0] PHYS_LOW_SET_ADDR = 12'h118;
  localparam logic [11:0] PHYS_LOW_CLEAR_ADDR = 12'h11C;
  localparam logic [31:0] FILTER_RESET = 32'h00000000;
  localparam int ALL_BUSES_BIT = 31;
  localparam logic [5:0] HIGH_NODE_BASE = 6'h20;
  localparam logic [5:0] LOCAL_BUS_ID = 6'h3F;
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_ASYNC,
    ROUTE_PHYS
  } route_t;
endpackage

// ==== sim/remote_node_model.sv ====
// remote bus node model that sends filter requests
`timescale 1ns/100ps
`default_nettype none
module remote_node_model (
  input wire logic clock,
  output logic req_valid,
  output logic req_phys,
  output logic [9:0] req_bus_id,
  output logic [5:0] req_node_id
);
  initial begin
    req_valid = 1'b0;
    req_phys = 1'b0;
    req_bus_id = 10'h3FF;
    req_node_id = 6'h3F;
  end
  // fields inverted when idle so a stale id cannot pass for a match
  task automatic send(input logic phys, input logic [9:0] bus, input logic [5:0] node);
    @(posedge clock);
    req_valid <= 1'b1;
    req_phys <= phys;
    req_bus_id <= bus;
    req_node_id <= node;
    @(posedge clock);
    req_valid <= 1'b0;
    req_phys <= ~phys;
    req_bus_id <= ~bus;
    req_node_id <= ~node;
  endtask
endmodule
`default_nettype wire

// ==== sim/node_request_filter_test.sv ====
// self-checking bench for the node request filter
`timescale 1ns/100ps
`default_nettype none
module node_request_filter_test;
  import node_filter_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic req_valid, req_phys, dec_valid, dec_accept, dec_to_phys, dec_to_async;
  logic [9:0] req_bus_id;
  logic [5:0] req_node_id;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  node_request_filter dut_u (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .req_valid(req_valid), .req_phys(req_phys),
    .req_bus_id(req_bus_id), .req_node_id(req_node_id), .dec_valid(dec_valid),
    .dec_accept(dec_accept), .dec_to_phys(dec_to_phys), .dec_to_async(dec_to_async));
  remote_node_model p_u (.clock(clock), .req_valid(req_valid), .req_phys(req_phys),
    .req_bus_id(req_bus_id), .req_node_id(req_node_id));
  // ************
  // bus and compare tasks
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic chk_dec(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // expected order: valid, accept, to physical, to async
  task automatic req(input logic ph, input logic [9:0] b, input logic [5:0] n, input logic [3:0] e);
    p_u.send(ph, b, n);
    #1 chk_dec({dec_valid, dec_accept, dec_to_phys, dec_to_async}, e);
  endtask
  task automatic finish_test;
    $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_setclr;
    rd_chk(12'h108, 32'h00000000);
    rd_chk(12'h110, 32'h00000000);
    wr_reg(12'h108, 32'h80000021);
    rd_chk(12'h108, 32'h80000021);
    wr_reg(12'h108, 32'h00000000);
    rd_chk(12'h108, 32'h80000021);
    wr_reg(12'h10C, 32'h00000001);
    rd_chk(12'h10C, 32'h80000020);
    wr_reg(12'h200, 32'hFFFFFFFF);
    rd_chk(12'h200, 32'h00000000);
    $display("test setclr done");
  endtask
  task automatic t_low;
    req(1'b0, 10'h3FF, 6'h05, 4'hD);
    req(1'b0, 10'h3FF, 6'h00, 4'h8);
    req(1'b1, 10'h3FF, 6'h05, 4'hD);
    $display("test low done");
  endtask
  task automatic t_high;
    wr_reg(12'h100, 32'h40040001);
    wr_reg(12'h110, 32'h40000001);
    req(1'b1, 10'h03F, 6'h3E, 4'hE);
    req(1'b1, 10'h03F, 6'h32, 4'hD);
    req(1'b1, 10'h03F, 6'h20, 4'hE);
    req(1'b1, 10'h03F, 6'h3D, 4'h8);
    wr_reg(12'h110, 32'h00040000);
    req(1'b1, 10'h03F, 6'h32, 4'hE);
    wr_reg(12'h114, 32'h40000000);
    rd_chk(12'h110, 32'h00040001);
    $display("test high done");
  endtask
  task automatic t_remote;
    req(1'b1, 10'h001, 6'h07, 4'h8);
    wr_reg(12'h100, 32'h80000000);
    req(1'b1, 10'h001, 6'h07, 4'hD);
    wr_reg(12'h110, 32'h80000000);
    req(1'b1, 10'h001, 6'h07, 4'hE);
    $display("test remote done");
  endtask
  task automatic t_extra;
    wr_reg(12'h118, 32'h00000020);
    req(1'b1, 10'h3FF, 6'h05, 4'hE);
    rd_chk(12'h11C, 32'h00000020);
    wr_reg(12'h11C, 32'h00000020);
    req(1'b1, 10'h3FF, 6'h05, 4'hD);
    req(1'b1, 10'h03F, 6'h3F, 4'h8);
    wr_reg(12'h104, 32'h00000001);
    req(1'b1, 10'h03F, 6'h20, 4'h8);
    rd_chk(12'h100, 32'hC0040000);
    rd_chk(12'h114, 32'h80040001);
    $display("test extra done");
  endtask
  // reset in mid-run must wipe every filter
  task automatic t_reset;
    @(posedge clock);
    srst <= 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd_chk(12'h100, 32'h00000000);
    rd_chk(12'h108, 32'h00000000);
    rd_chk(12'h110, 32'h00000000);
    rd_chk(12'h118, 32'h00000000);
    req(1'b1, 10'h3FF, 6'h05, 4'h8);
    $display("test reset done");
  endtask
  always @(posedge clock) begin
    cycles++;
    // far beyond the roughly one hundred cycles the tests need
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_setclr();
    t_low();
    t_high();
    t_remote();
    t_extra();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
